// ===== logic/spio_pkg.sv
// constants, types and helpers shared by the parallel port design
// assumes a 32-bit classic Wishbone register bus, byte-addressed
package spio_pkg;
   // widest port that one 32-bit register can hold
   localparam int unsigned MAX_WIDTH = 32;
   // byte address width seen by the slave
   localparam int unsigned ADR_W     = 8;
   // register byte offsets
   localparam logic [7:0]  OFS_DIR   = 8'h00;  // pin_direction_reg
   localparam logic [7:0]  OFS_LAT   = 8'h04;  // output_latch_reg
   localparam logic [7:0]  OFS_LVL   = 8'h08;  // pin_level_reg
   localparam logic [7:0]  OFS_OWN   = 8'h0C;  // pins held by peripherals
   localparam logic [7:0]  OFS_IMPL  = 8'h10;  // implemented pin mask
   // reset values
   localparam logic [31:0] DIR_RST   = 32'hFFFF_FFFF;  // all inputs
   localparam logic [31:0] LAT_RST   = 32'h0000_0000;
   localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

   // bus slave states
   typedef enum logic [0:0] {
      SPIO_BUS_IDLE = 1'b0,  // waiting for a request
      SPIO_BUS_ACK  = 1'b1   // acknowledge cycle
   } spio_bus_t;

   // word-aligned address match, low two bits ignored
   function automatic logic spio_hit(input logic [7:0] adr,
                                     input logic [7:0] ofs);
      return adr[7:2] == ofs[7:2];
   endfunction

   // byte-lane merge of write data under sel
   function automatic logic [31:0] spio_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction
endpackage

// ===== logic/spio_mux_if.sv
// control and pin signals between the port registers and the
// output multiplexers; both ends sit on the same clock
`timescale 1ns/1ns
interface spio_mux_if #(parameter int unsigned WIDTH = 16);
   logic [WIDTH-1:0] lat;     // output latch contents
   logic [WIDTH-1:0] dir;     // direction, 1 = input
   logic [WIDTH-1:0] impl;    // implemented pins
   logic [WIDTH-1:0] ionly;   // pins whose peripheral is input-only
   logic [WIDTH-1:0] p_en;    // peripheral enabled
   logic [WIDTH-1:0] p_oe;    // peripheral wants to drive
   logic [WIDTH-1:0] p_do;    // peripheral output data
   logic [WIDTH-1:0] pin_i;   // pin level in
   logic [WIDTH-1:0] pin_o;   // pin level out
   logic [WIDTH-1:0] pin_oe;  // pin driver enable
   logic [WIDTH-1:0] p_di;    // peripheral input data
   logic [WIDTH-1:0] owned;   // pin held by a peripheral

   // register side
   modport ctrl (output lat, dir, impl, ionly, p_en, p_oe, p_do, pin_i,
                 input  pin_o, pin_oe, p_di, owned);
   // multiplexer side
   modport mux  (input  lat, dir, impl, ionly, p_en, p_oe, p_do, pin_i,
                 output pin_o, pin_oe, p_di, owned);
endinterface

// ===== logic/spio_out_mux.sv
// per-pin output multiplexers: peripheral or port owns each pin
// assumes all inputs are synchronous to clk
`timescale 1ns/1ns
module spio_out_mux #(
   parameter int unsigned WIDTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register side
   spio_mux_if.mux  m
);
   logic [WIDTH-1:0] own_w;        // peripheral holds the pin
   logic [WIDTH-1:0] port_w;       // port drives the pin
   logic [WIDTH-1:0] pin_o_reg;    // registered pin data
   logic [WIDTH-1:0] pin_oe_reg;   // registered pin enable
   logic [WIDTH-1:0] p_di_reg;     // registered peripheral input
   logic [WIDTH-1:0] owned_reg;    // registered ownership

   // ownership decode; an input-only peripheral never takes a pin
   assign own_w  = m.p_en & m.p_oe & ~m.ionly & m.impl;
   // port drives only when not owned and direction is output
   assign port_w = ~own_w & ~m.dir & m.impl;

   // output data and enable multiplexers
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_o_reg  <= '0;
         pin_oe_reg <= '0;
      end else begin
         pin_o_reg  <= (own_w & m.p_do) | (~own_w & m.lat & m.impl);
         pin_oe_reg <= own_w | port_w;
      end
   end

   // peripheral input, blocked while the port drives that pin
   always_ff @(posedge clk) begin
      if (rst) begin
         p_di_reg  <= '0;
         owned_reg <= '0;
      end else begin
         p_di_reg  <= m.pin_i & ~port_w & m.impl;
         owned_reg <= own_w;
      end
   end

   assign m.pin_o  = pin_o_reg;
   assign m.pin_oe = pin_oe_reg;
   assign m.p_di   = p_di_reg;
   assign m.owned  = owned_reg;

   default clocking mcb @(posedge clk); endclocking
   default disable iff (rst);

   a_periph_data_out: assert property (
      (own_w != '0) |=> ((pin_o_reg & $past(own_w))
                         == ($past(m.p_do) & $past(own_w))))
      else $error("peripheral data not on owned pin");
   a_owned_drives: assert property (
      (own_w != '0) |=> ((pin_oe_reg & $past(own_w)) == $past(own_w)))
      else $error("owned pin not enabled");
   a_port_drives: assert property (
      (port_w != '0) |=> ((pin_oe_reg & $past(port_w)) == $past(port_w))
                         and ((pin_o_reg & $past(port_w))
                              == ($past(m.lat) & $past(port_w))))
      else $error("port output not driven from latch");
   a_dir_input: assert property (
      ((m.dir & ~own_w) != '0) |=>
         ((pin_oe_reg & $past(m.dir & ~own_w)) == '0))
      else $error("input pin driven");
   a_loop_block: assert property (
      ##1 ((p_di_reg & $past(port_w)) == '0))
      else $error("port output looped into peripheral");
   a_impl_quiet: assert property (
      ##1 (((pin_oe_reg | pin_o_reg | p_di_reg) & ~m.impl) == '0))
      else $error("unimplemented pin active");
   a_input_only: assert property (
      ##1 ((owned_reg & m.ionly) == '0))
      else $error("input-only peripheral took a pin");
   c_periph_owns: cover property ((own_w != '0) ##1 (owned_reg != '0));
   c_port_owns: cover property ((port_w != '0) ##1 (pin_oe_reg != '0));
endmodule

// ===== logic/spio_port_top.sv
// shared parallel port: direction, latch and level registers on a
// classic Wishbone slave, with pin ownership handed to peripherals
// assumes pins and peripheral signals are synchronous to CLK
`timescale 1ns/1ns
module spio_port_top #(
   parameter int unsigned      WIDTH      = 16,
   parameter logic [WIDTH-1:0] IMPL_MASK  = '1,
   parameter logic [WIDTH-1:0] IONLY_MASK = '0
) (
   // clock and reset
   input  wire logic                        CLK,
   input  wire logic                        SYS_RST,
   // wishbone slave
   input  wire logic                        WB_CYC_I,
   input  wire logic                        WB_STB_I,
   input  wire logic                        WB_WE_I,
   input  wire logic [spio_pkg::ADR_W-1:0]  WB_ADR_I,
   input  wire logic [3:0]                  WB_SEL_I,
   input  wire logic [31:0]                 WB_DAT_I,
   output wire logic [31:0]                 WB_DAT_O,
   output wire logic                        WB_ACK_O,
   // sharing peripherals
   input  wire logic [WIDTH-1:0]            PERIPH_EN,
   input  wire logic [WIDTH-1:0]            PERIPH_OE,
   input  wire logic [WIDTH-1:0]            PERIPH_DO,
   output wire logic [WIDTH-1:0]            PERIPH_DI,
   // pins
   input  wire logic [WIDTH-1:0]            PIN_I,
   output wire logic [WIDTH-1:0]            PIN_O,
   output wire logic [WIDTH-1:0]            PIN_OE
);
   // refuse widths one register cannot hold
   if (WIDTH < 1 || WIDTH > spio_pkg::MAX_WIDTH) begin : g_chk
      $error("spio_port_top: WIDTH must be 1 to 32");
   end

   spio_mux_if #(.WIDTH(WIDTH)) mif ();

   spio_pkg::spio_bus_t state_reg;    // bus slave state
   spio_pkg::spio_bus_t state_next;   // its next value
   logic [WIDTH-1:0]    dir_reg;      // pin_direction_reg
   logic [WIDTH-1:0]    lat_reg;      // output_latch_reg
   logic [WIDTH-1:0]    lvl_meta_reg; // synchroniser first stage
   logic [WIDTH-1:0]    lvl_sync_reg; // synchroniser second stage
   logic [31:0]         rdata_reg;    // registered read data
   logic [31:0]         rd_val;       // read data before the flop
   logic                req;          // request present
   logic                wr_fire;      // write takes effect this edge
   logic                rd_take;      // read taken on this edge
   logic [31:0]         dir_merged;   // direction after byte merge
   logic [31:0]         lat_merged;   // latch after byte merge
   logic                hit_dir;      // address decodes
   logic                hit_lat;
   logic                hit_lvl;
   logic                hit_own;
   logic                hit_impl;
   logic [WIDTH-1:0]    dir_rst_w;    // reset direction, masked

   // address decode
   assign hit_dir  = spio_pkg::spio_hit(WB_ADR_I, spio_pkg::OFS_DIR);
   assign hit_lat  = spio_pkg::spio_hit(WB_ADR_I, spio_pkg::OFS_LAT);
   assign hit_lvl  = spio_pkg::spio_hit(WB_ADR_I, spio_pkg::OFS_LVL);
   assign hit_own  = spio_pkg::spio_hit(WB_ADR_I, spio_pkg::OFS_OWN);
   assign hit_impl = spio_pkg::spio_hit(WB_ADR_I, spio_pkg::OFS_IMPL);

   assign req     = WB_CYC_I & WB_STB_I;
   // writes land on the edge that the master sees ack
   assign wr_fire = req & WB_WE_I & (state_reg == spio_pkg::SPIO_BUS_ACK);
   // a read is taken while the slave is idle
   assign rd_take = req & ~WB_WE_I & (state_reg == spio_pkg::SPIO_BUS_IDLE);

   // next state of the bus slave
   always_comb begin
      case (state_reg)
         spio_pkg::SPIO_BUS_IDLE: begin
            // answer any request one cycle later
            state_next = req ? spio_pkg::SPIO_BUS_ACK
                             : spio_pkg::SPIO_BUS_IDLE;
         end
         spio_pkg::SPIO_BUS_ACK: begin
            // ack lasts one cycle
            state_next = spio_pkg::SPIO_BUS_IDLE;
         end
         default: begin
            state_next = spio_pkg::SPIO_BUS_IDLE;
         end
      endcase
   end

   // bus state register
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state_reg <= spio_pkg::SPIO_BUS_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign WB_ACK_O = (state_reg == spio_pkg::SPIO_BUS_ACK);

   // read multiplexer; unmapped addresses read zero
   always_comb begin
      rd_val = spio_pkg::RD_ZERO;
      if (hit_dir) begin
         rd_val = 32'(dir_reg & IMPL_MASK);
      end else if (hit_lat) begin
         rd_val = 32'(lat_reg & IMPL_MASK);
      end else if (hit_lvl) begin
         rd_val = 32'(lvl_sync_reg & IMPL_MASK);
      end else if (hit_own) begin
         rd_val = 32'(mif.owned);
      end else if (hit_impl) begin
         rd_val = 32'(IMPL_MASK);
      end
   end

   // read data captured as the ack is raised
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         rdata_reg <= spio_pkg::RD_ZERO;
      end else if (req && state_reg == spio_pkg::SPIO_BUS_IDLE) begin
         rdata_reg <= rd_val;
      end
   end

   assign WB_DAT_O = rdata_reg;

   // byte-lane merges for the two writable registers
   assign dir_merged = spio_pkg::spio_merge(32'(dir_reg), WB_DAT_I,
                                            WB_SEL_I);
   assign lat_merged = spio_pkg::spio_merge(32'(lat_reg), WB_DAT_I,
                                            WB_SEL_I);
   assign dir_rst_w  = spio_pkg::DIR_RST[WIDTH-1:0] & IMPL_MASK;

   // direction register, all inputs after reset
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         dir_reg <= dir_rst_w;
      end else if (wr_fire && hit_dir) begin
         dir_reg <= dir_merged[WIDTH-1:0] & IMPL_MASK;
      end
   end

   // output latch, written through latch or level address
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         lat_reg <= spio_pkg::LAT_RST[WIDTH-1:0];
      end else if (wr_fire && (hit_lat || hit_lvl)) begin
         lat_reg <= lat_merged[WIDTH-1:0] & IMPL_MASK;
      end
   end

   // pin level synchroniser
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         lvl_meta_reg <= '0;
         lvl_sync_reg <= '0;
      end else begin
         lvl_meta_reg <= PIN_I;
         lvl_sync_reg <= lvl_meta_reg;
      end
   end

   // hand the pin controls to the multiplexers
   assign mif.lat   = lat_reg;
   assign mif.dir   = dir_reg;
   assign mif.impl  = IMPL_MASK;
   assign mif.ionly = IONLY_MASK;
   assign mif.p_en  = PERIPH_EN;
   assign mif.p_oe  = PERIPH_OE;
   assign mif.p_do  = PERIPH_DO;
   assign mif.pin_i = PIN_I;

   spio_out_mux #(.WIDTH(WIDTH)) u_mux (
      .clk (CLK),
      .rst (SYS_RST),
      .m   (mif.mux)
   );

   assign PIN_O     = mif.pin_o;
   assign PIN_OE    = mif.pin_oe;
   assign PERIPH_DI = mif.p_di;

   // every check below runs on CLK and sleeps in reset
   default clocking tcb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   a_reset_dir: assert property (
      $past(SYS_RST) |-> (dir_reg == dir_rst_w))
      else $error("direction not all inputs after reset");
   a_lat_write: assert property (
      (wr_fire && hit_lat && WB_SEL_I == 4'hF) |=>
         (lat_reg == ($past(WB_DAT_I[WIDTH-1:0]) & IMPL_MASK)))
      else $error("latch write lost");
   a_lvl_write: assert property (
      (wr_fire && hit_lvl && WB_SEL_I == 4'hF) |=>
         (lat_reg == ($past(WB_DAT_I[WIDTH-1:0]) & IMPL_MASK)))
      else $error("level write did not reach latch");
   a_lvl_read: assert property (
      (req && !WB_WE_I && hit_lvl && state_reg == spio_pkg::SPIO_BUS_IDLE
       && !$past(SYS_RST, 2)) |=>
         (WB_DAT_O == 32'($past(PIN_I, 3) & IMPL_MASK)))
      else $error("level read not from synchronised pins");
   a_dir_mask: assert property (
      ##1 ((dir_reg & ~IMPL_MASK) == '0 && (lat_reg & ~IMPL_MASK) == '0))
      else $error("unimplemented bit stored");
   a_ack_single: assert property (
      WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");

   // a request taken while idle is answered on the next edge
   a_ack_next: assert property (
      (req && state_reg == spio_pkg::SPIO_BUS_IDLE) |=> WB_ACK_O)
      else $error("request not answered in one cycle");
   // no answer while the slave idles without a request
   a_ack_idle: assert property (
      (state_reg == spio_pkg::SPIO_BUS_IDLE && !req) |=> !WB_ACK_O)
      else $error("ack raised with no request");
   // never an answer without a request behind it
   a_ack_cause: assert property (
      WB_ACK_O |-> $past(req))
      else $error("ack without request");

   // read data is the word selected when the read was taken
   a_dir_read: assert property (
      rd_take && hit_dir |=> (WB_DAT_O == 32'($past(dir_reg) & IMPL_MASK)))
      else $error("direction read wrong");
   a_lat_read: assert property (
      rd_take && hit_lat |=> (WB_DAT_O == 32'($past(lat_reg) & IMPL_MASK)))
      else $error("latch read wrong");
   a_own_read: assert property (
      rd_take && hit_own |=> (WB_DAT_O == 32'($past(mif.owned))))
      else $error("owned pins read wrong");
   a_impl_read: assert property (
      rd_take && hit_impl |=> (WB_DAT_O == 32'(IMPL_MASK)))
      else $error("implemented mask read wrong");
   // any other address reads zero
   a_other_zero: assert property (
      rd_take && !(hit_dir || hit_lat || hit_lvl || hit_own || hit_impl)
      |=> (WB_DAT_O == spio_pkg::RD_ZERO))
      else $error("unmapped address read not zero");
   // read data stands until the next request is taken
   a_rdata_hold: assert property (
      !(req && state_reg == spio_pkg::SPIO_BUS_IDLE) |=> $stable(WB_DAT_O))
      else $error("read data changed between requests");

   // registers change only through a write that lands
   a_dir_hold: assert property (
      !(wr_fire && hit_dir) |=> $stable(dir_reg))
      else $error("direction changed without a write");
   a_lat_hold: assert property (
      !(wr_fire && (hit_lat || hit_lvl)) |=> $stable(lat_reg))
      else $error("latch changed without a write");
   a_dir_write: assert property (
      (wr_fire && hit_dir && WB_SEL_I == 4'hF) |=>
         (dir_reg == ($past(WB_DAT_I[WIDTH-1:0]) & IMPL_MASK)))
      else $error("direction write lost");
   // a level write goes to the latch, never the direction
   a_lvl_keeps_dir: assert property (
      (wr_fire && hit_lvl) |=> $stable(dir_reg))
      else $error("level write touched direction");
   // read-only places take no write
   a_ro_ignored: assert property (
      (wr_fire && (hit_own || hit_impl)) |=>
         ($stable(dir_reg) && $stable(lat_reg)))
      else $error("read-only write changed a register");
   // an unselected low byte keeps its latch and direction bits
   a_lat_sel: assert property (
      (wr_fire && (hit_lat || hit_lvl) && !WB_SEL_I[0]) |=>
         (lat_reg[0] == $past(lat_reg[0])))
      else $error("latch byte written without select");
   a_dir_sel: assert property (
      (wr_fire && hit_dir && !WB_SEL_I[0]) |=>
         (dir_reg[0] == $past(dir_reg[0])))
      else $error("direction byte written without select");

   // reset leaves no ack, no driven pin and a clear latch
   a_rst_quiet: assert property (
      $past(SYS_RST) |-> (!WB_ACK_O && PIN_OE == '0
                          && lat_reg == spio_pkg::LAT_RST[WIDTH-1:0]))
      else $error("outputs active after reset");
   // pin levels reach the level path two edges later
   a_sync_depth: assert property (
      !SYS_RST |-> ##2 (lvl_sync_reg == $past(PIN_I, 2)))
      else $error("synchroniser depth wrong");

   c_read_level: cover property (req && hit_lvl && !WB_WE_I ##1 WB_ACK_O);
   c_write_dir: cover property (wr_fire && hit_dir);
   c_write_lat: cover property (wr_fire && hit_lat);
endmodule

// ===== dv/spio_pad_model.sv
// pad and board model beside the parallel port: resolves each pin
// assumes the bench decides where an outside source drives the board
`timescale 1ns/1ns
module spio_pad_model #(
   parameter int unsigned W = 8
) (
   // clock
   input  wire logic         clk,
   // chip side
   input  wire logic [W-1:0] pin_o,
   input  wire logic [W-1:0] pin_oe,
   // board side
   input  wire logic [W-1:0] ext_en,
   input  wire logic [W-1:0] ext_val,
   // resolved level
   output wire logic [W-1:0] pin_i
);
   logic [W-1:0] float_reg = '0;  // undriven pins wander

   // toggle so a floating pin never looks like a stable value
   always_ff @(posedge clk) begin
      float_reg <= ~float_reg;
   end
   // chip driver wins, then board source, else floating pattern
   assign pin_i = (pin_oe & pin_o)
                | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & float_reg);
endmodule

// ===== dv/tb.sv
// self-checking bench for the shared parallel port
// assumes the design answers every bus request within a few cycles
`timescale 1ns/1ns
module tb;
   localparam logic [7:0] IMPL  = 8'h7F;  // top bit unimplemented
   localparam logic [7:0] IONLY = 8'h40;  // pin 6 input-only sharing
   logic        clk     = 1'b0;     // system clock
   logic        sys_rst = 1'b1;     // sync reset
   logic        cyc     = 1'b0;     // bus cycle
   logic        stb     = 1'b0;     // bus strobe
   logic        we      = 1'b0;     // bus direction
   logic [7:0]  adr     = 8'h00;    // bus address
   logic [31:0] wdat    = 32'h0;    // bus write data
   logic [3:0]  sel     = 4'h0;     // bus byte enables
   wire  [31:0] rdat;               // bus read data
   wire         ack;                // bus acknowledge
   logic [7:0]  p_en    = 8'h00;    // peripheral enables
   logic [7:0]  p_oe    = 8'h00;    // peripheral drive requests
   logic [7:0]  p_do    = 8'h00;    // peripheral data out
   wire  [7:0]  p_di;               // peripheral data in
   wire  [7:0]  pin_i;              // resolved pins
   wire  [7:0]  pin_o;              // port pin data
   wire  [7:0]  pin_oe;             // port pin enables
   logic [7:0]  ext_en  = 8'hFF;    // board drives every pin
   logic [7:0]  ext_val = 8'hA5;    // board level
   int          err_count   = 0;    // mismatches
   int          comparisons = 0;    // checks made

   always #2 clk = ~clk;

   spio_port_top #(.WIDTH(8), .IMPL_MASK(IMPL), .IONLY_MASK(IONLY))
   spio_port_top_i (
      .CLK(clk), .SYS_RST(sys_rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
      .WB_DAT_O(rdat), .WB_ACK_O(ack), .PERIPH_EN(p_en),
      .PERIPH_OE(p_oe), .PERIPH_DO(p_do), .PERIPH_DI(p_di),
      .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe));

   spio_pad_model #(.W(8)) spio_pad_model_i (
      .clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .ext_en(ext_en),
      .ext_val(ext_val), .pin_i(pin_i));

   // compare and report one value
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask

   // one classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q);
      int n;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= s;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      chk("ack", 32'h1, {31'h0, ack});
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      sel <= 4'h0;
   endtask

   // register write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, 4'hF, q);
   endtask

   // register read against an expected word
   task automatic rd(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, 4'hF, q);
      chk(nm, e, q);
   endtask

   // let registered pins and the synchroniser catch up
   task automatic settle;
      repeat (4) @(posedge clk);
      #1;
   endtask

   // reset for five cycles with peripherals released
   task automatic do_reset;
      @(posedge clk);
      sys_rst <= 1'b1;
      p_en    <= 8'h00;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
   endtask

   // reset values of the direction, latch and implemented mask registers and the pin enables
   task automatic t_reset;
      do_reset();
      rd("dir", spio_pkg::OFS_DIR, {24'h0, IMPL});
      rd("lat", spio_pkg::OFS_LAT, 32'h0);
      rd("impl", spio_pkg::OFS_IMPL, {24'h0, IMPL});
      #1;
      chk("pin_oe", 32'h0, {24'h0, pin_oe});
   endtask

   // latch, level write, read-only and unmapped places, direction
   task automatic t_regs;
      logic [31:0] q;
      wr(spio_pkg::OFS_LAT, 32'hFF);
      rd("lat", spio_pkg::OFS_LAT, 32'h7F);
      wr(spio_pkg::OFS_LVL, 32'h0F);
      rd("lat", spio_pkg::OFS_LAT, 32'h0F);
      wb(1'b1, spio_pkg::OFS_LAT, 32'hF0F0, 4'h2, q);
      rd("lat_sel", spio_pkg::OFS_LAT, 32'h0F);
      wr(spio_pkg::OFS_OWN, 32'hFF);
      rd("own", spio_pkg::OFS_OWN, 32'h0);
      wr(8'h20, 32'hFF);
      rd("unmapped", 8'h20, 32'h0);
      wr(spio_pkg::OFS_DIR, 32'h33);
      settle();
      chk("pin_oe", 32'h4C, {24'h0, pin_oe});
      chk("pin_o", 32'h0C, {24'h0, pin_o & pin_oe});
      rd("level", spio_pkg::OFS_LVL, 32'h2D);
      chk("p_di", 32'h21, {24'h0, p_di});
   endtask

   // peripherals take pins 0 and 1, idle on 2, input-only on 6
   task automatic t_share;
      @(posedge clk);
      p_en <= 8'h47;
      p_oe <= 8'h43;
      p_do <= 8'hFE;
      settle();
      chk("pin_oe", 32'h4F, {24'h0, pin_oe});
      chk("pin_o", 32'h0E, {24'h0, pin_o & pin_oe});
      chk("p_di", 32'h22, {24'h0, p_di});
      rd("level", spio_pkg::OFS_LVL, 32'h2E);
      rd("own", spio_pkg::OFS_OWN, 32'h03);
      wr(spio_pkg::OFS_DIR, 32'h00);
      settle();
      chk("pin_oe", 32'h7F, {24'h0, pin_oe});
      chk("pin_o", 32'h0E, {24'h0, pin_o});
   endtask

   // verdict and end of run
   task automatic give_verdict;
      if (err_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // main sequence, reset again at the end
   initial begin
      t_reset();
      t_regs();
      t_share();
      t_reset();
      give_verdict();
   end

   // watchdog well beyond the fewer than a hundred cycles needed
   initial begin
      #20000;
      err_count++;
      give_verdict();
   end
endmodule
